// file: rtl/dual_timer_pkg.sv
package dual_timer_pkg;

	// Register addresses
	localparam logic [15:0] ADDR_PORT3_LATCH = 16'hFF03;
	localparam logic [15:0] ADDR_PORT3_DIR = 16'hFF23;
	localparam logic [15:0] ADDR_CMP_CH1 = 16'hFF10;
	localparam logic [15:0] ADDR_CMP_CH2 = 16'hFF11;
	localparam logic [15:0] ADDR_COUNT_CH1 = 16'hFF12;
	localparam logic [15:0] ADDR_COUNT_CH2 = 16'hFF13;
	localparam logic [15:0] ADDR_MODE_CTRL = 16'hFF49;
	localparam logic [15:0] ADDR_OUT_CTRL = 16'hFF4F;

	// Reset values
	localparam logic [7:0] RST_MODE_CTRL = 8'h00;
	localparam logic [7:0] RST_OUT_CTRL = 8'h00;
	localparam logic [7:0] RST_PORT3_DIR = 8'hFF;
	localparam logic [7:0] RST_PORT3_LATCH = 8'h00;
	localparam logic [7:0] RST_CMP = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;

	// Mode-control fields
	localparam int MODE_RUN_CH1 = 0;
	localparam int MODE_RUN_CH2 = 1;
	localparam int MODE_CASCADE = 2;

	// Output-control fields
	localparam int OC_DRIVE_EN_CH1 = 0;
	localparam int OC_TOGGLE_EN_CH1 = 1;
	localparam int OC_CLEAR_CH1 = 2;
	localparam int OC_SET_CH1 = 3;
	localparam int OC_DRIVE_EN_CH2 = 4;
	localparam int OC_TOGGLE_EN_CH2 = 5;
	localparam int OC_CLEAR_CH2 = 6;
	localparam int OC_SET_CH2 = 7;
	// Action bits never stored, so they read back as zero
	localparam logic [7:0] OC_STORED_MASK = 8'h33;

	// Port 3 pins shared with the timer outputs
	localparam int PIN_A = 1;
	localparam int PIN_B = 2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_mode;
		logic [2:0] bit_sel;
		logic [15:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic out_a;
		logic oe_a;
		logic out_b;
		logic oe_b;
	} pin_drive_t;

endpackage : dual_timer_pkg

// file: rtl/timer_out_flop.sv
`timescale 1ns/100ps
module timer_out_flop (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic set_req,
	input wire logic clear_req,
	input wire logic toggle_en,
	input wire logic match,
	output logic level
);
	logic next_level;

	always_comb begin
		next_level = level;
		if (set_req && !clear_req) begin
			next_level = 1'b1;
		end else if (clear_req && !set_req) begin
			next_level = 1'b0;
		end else if (set_req && clear_req) begin
			// Prohibited pattern: hold the level rather than pick a side
			next_level = level;
		end else if (toggle_en && match) begin
			next_level = ~level;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			level <= 1'b0;
		end else begin
			level <= next_level;
		end
	end
endmodule : timer_out_flop

// file: rtl/dual_timer_output_control.sv
`timescale 1ns/100ps
// Operation
// - Mode register runs counters, selects mode, resets 00H
// - Mode register takes bit and byte writes
// - Cascaded mode runs on first run bit only
// - Output control register resets to zero
// - Output control takes bit and byte writes
// - Bit 0 drives channel 1 flop to pin
// - Bit 1 enables channel 1 toggling
// - Bits 3/2 set or clear channel 1 flop
// - Bit 4 drives channel 2 flop to pin
// - Bit 5 enables channel 2 toggling
// - Bits 7/6 set or clear channel 2 flop
// - Set and clear bits read back zero
// - Port 3 direction per bit, resets FFH
// - Compare match clears counter and raises request
module dual_timer_output_control (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire dual_timer_pkg::reg_req_t reg_req,
	input wire logic tick_ch1,
	input wire logic tick_ch2,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic match_irq_ch1,
	output logic match_irq_ch2,
	output dual_timer_pkg::pin_drive_t pins
);
	logic [7:0] counter_mode_ctrl_reg;
	logic [7:0] output_ctrl_reg;
	logic [7:0] port3_direction_reg;
	logic [7:0] port3_latch;
	logic [7:0] cmp_ch1;
	logic [7:0] cmp_ch2;
	logic [7:0] counter_ch1;
	logic [7:0] counter_ch2;
	logic [7:0] next_mode;
	logic [7:0] next_out_ctrl;
	logic [7:0] next_dir;
	logic [7:0] next_latch;
	logic [7:0] next_cmp1;
	logic [7:0] next_cmp2;
	logic [7:0] next_cnt1;
	logic [7:0] next_cnt2;
	logic [7:0] next_rdata;
	logic next_irq1;
	logic next_irq2;
	logic [7:0] oc_write;
	logic oc_hit;
	logic flop_set_ch1;
	logic flop_clear_ch1;
	logic flop_set_ch2;
	logic flop_clear_ch2;
	logic out_flop_ch1;
	logic out_flop_ch2;
	logic cascade;
	dual_timer_pkg::pin_drive_t next_pins;

	// Applies a byte write or a one-bit write to a register at the given address
	function automatic logic [7:0] reg_write(input logic [7:0] old,
			input dual_timer_pkg::reg_req_t req, input logic [15:0] addr);
		logic [7:0] res;
		res = old;
		if (req.wr && req.addr == addr) begin
			if (req.bit_mode) begin
				res[req.bit_sel] = req.wdata[0];
			end else begin
				res = req.wdata;
			end
		end
		return res;
	endfunction : reg_write

	// One counting step: clear on match, else increment
	function automatic logic [8:0] count_step(input logic [7:0] cnt, input logic [7:0] cmp);
		if (cnt == cmp) begin
			return {1'b1, 8'h00};
		end
		return {1'b0, 8'(cnt + 8'h01)};
	endfunction : count_step

	assign cascade = counter_mode_ctrl_reg[dual_timer_pkg::MODE_CASCADE];
	assign oc_hit = reg_req.wr && reg_req.addr == dual_timer_pkg::ADDR_OUT_CTRL;
	// Action bits are seen only as the write's own image; old value counts as zero
	assign oc_write = reg_write(output_ctrl_reg & dual_timer_pkg::OC_STORED_MASK,
			reg_req, dual_timer_pkg::ADDR_OUT_CTRL);
	assign flop_set_ch1 = oc_hit && oc_write[dual_timer_pkg::OC_SET_CH1];
	assign flop_clear_ch1 = oc_hit && oc_write[dual_timer_pkg::OC_CLEAR_CH1];
	assign flop_set_ch2 = oc_hit && oc_write[dual_timer_pkg::OC_SET_CH2];
	assign flop_clear_ch2 = oc_hit && oc_write[dual_timer_pkg::OC_CLEAR_CH2];

	// Register file
	always_comb begin
		next_mode = reg_write(counter_mode_ctrl_reg, reg_req,
				dual_timer_pkg::ADDR_MODE_CTRL);
		next_out_ctrl = oc_write & dual_timer_pkg::OC_STORED_MASK;
		next_dir = reg_write(port3_direction_reg, reg_req,
				dual_timer_pkg::ADDR_PORT3_DIR);
		next_latch = reg_write(port3_latch, reg_req, dual_timer_pkg::ADDR_PORT3_LATCH);
		next_cmp1 = reg_write(cmp_ch1, reg_req, dual_timer_pkg::ADDR_CMP_CH1);
		next_cmp2 = reg_write(cmp_ch2, reg_req, dual_timer_pkg::ADDR_CMP_CH2);
		next_rdata = 8'h00;
		case (reg_req.addr)
			dual_timer_pkg::ADDR_MODE_CTRL: next_rdata = counter_mode_ctrl_reg;
			dual_timer_pkg::ADDR_OUT_CTRL: next_rdata = output_ctrl_reg;
			dual_timer_pkg::ADDR_PORT3_DIR: next_rdata = port3_direction_reg;
			dual_timer_pkg::ADDR_PORT3_LATCH: next_rdata = port3_latch;
			dual_timer_pkg::ADDR_CMP_CH1: next_rdata = cmp_ch1;
			dual_timer_pkg::ADDR_CMP_CH2: next_rdata = cmp_ch2;
			dual_timer_pkg::ADDR_COUNT_CH1: next_rdata = counter_ch1;
			dual_timer_pkg::ADDR_COUNT_CH2: next_rdata = counter_ch2;
			default: next_rdata = 8'h00;
		endcase
		if (!reg_req.rd) begin
			next_rdata = reg_rdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			counter_mode_ctrl_reg <= dual_timer_pkg::RST_MODE_CTRL;
			output_ctrl_reg <= dual_timer_pkg::RST_OUT_CTRL;
			port3_direction_reg <= dual_timer_pkg::RST_PORT3_DIR;
			port3_latch <= dual_timer_pkg::RST_PORT3_LATCH;
			cmp_ch1 <= dual_timer_pkg::RST_CMP;
			cmp_ch2 <= dual_timer_pkg::RST_CMP;
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			counter_mode_ctrl_reg <= next_mode;
			output_ctrl_reg <= next_out_ctrl;
			port3_direction_reg <= next_dir;
			port3_latch <= next_latch;
			cmp_ch1 <= next_cmp1;
			cmp_ch2 <= next_cmp2;
			reg_rdata <= next_rdata;
			reg_rvalid <= reg_req.rd;
		end
	end

	// Counters; a stopped counter is held at zero
	always_comb begin
		logic [8:0] step1;
		logic [8:0] step2;
		step1 = count_step(counter_ch1, cmp_ch1);
		step2 = count_step(counter_ch2, cmp_ch2);
		next_cnt1 = counter_ch1;
		next_cnt2 = counter_ch2;
		next_irq1 = 1'b0;
		next_irq2 = 1'b0;
		if (cascade) begin
			// Second run bit is ignored here: one bit owns the 16-bit pair
			if (!counter_mode_ctrl_reg[dual_timer_pkg::MODE_RUN_CH1]) begin
				next_cnt1 = dual_timer_pkg::RST_COUNT;
				next_cnt2 = dual_timer_pkg::RST_COUNT;
			end else if (tick_ch1) begin
				if ({counter_ch2, counter_ch1} == {cmp_ch2, cmp_ch1}) begin
					next_cnt1 = 8'h00;
					next_cnt2 = 8'h00;
					next_irq1 = 1'b1;
					next_irq2 = 1'b1;
				end else begin
					{next_cnt2, next_cnt1} = 16'({counter_ch2, counter_ch1} + 16'h0001);
				end
			end
		end else begin
			if (!counter_mode_ctrl_reg[dual_timer_pkg::MODE_RUN_CH1]) begin
				next_cnt1 = dual_timer_pkg::RST_COUNT;
			end else if (tick_ch1) begin
				{next_irq1, next_cnt1} = step1;
			end
			if (!counter_mode_ctrl_reg[dual_timer_pkg::MODE_RUN_CH2]) begin
				next_cnt2 = dual_timer_pkg::RST_COUNT;
			end else if (tick_ch2) begin
				{next_irq2, next_cnt2} = step2;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			counter_ch1 <= dual_timer_pkg::RST_COUNT;
			counter_ch2 <= dual_timer_pkg::RST_COUNT;
			match_irq_ch1 <= 1'b0;
			match_irq_ch2 <= 1'b0;
		end else begin
			counter_ch1 <= next_cnt1;
			counter_ch2 <= next_cnt2;
			match_irq_ch1 <= next_irq1;
			match_irq_ch2 <= next_irq2;
		end
	end

	// Output flip-flops toggle on the registered match pulse
	timer_out_flop u_flop_ch1 (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.set_req(flop_set_ch1),
		.clear_req(flop_clear_ch1),
		.toggle_en(output_ctrl_reg[dual_timer_pkg::OC_TOGGLE_EN_CH1]),
		.match(match_irq_ch1),
		.level(out_flop_ch1)
	);

	timer_out_flop u_flop_ch2 (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.set_req(flop_set_ch2),
		.clear_req(flop_clear_ch2),
		.toggle_en(output_ctrl_reg[dual_timer_pkg::OC_TOGGLE_EN_CH2]),
		.match(match_irq_ch2),
		.level(out_flop_ch2)
	);

	// Pin mux: timer owns the data when enabled, direction bit owns the enable
	always_comb begin
		next_pins.out_a = port3_latch[dual_timer_pkg::PIN_A];
		next_pins.out_b = port3_latch[dual_timer_pkg::PIN_B];
		if (output_ctrl_reg[dual_timer_pkg::OC_DRIVE_EN_CH1]) begin
			next_pins.out_a = out_flop_ch1;
		end
		if (output_ctrl_reg[dual_timer_pkg::OC_DRIVE_EN_CH2]) begin
			next_pins.out_b = out_flop_ch2;
		end
		next_pins.oe_a = ~port3_direction_reg[dual_timer_pkg::PIN_A];
		next_pins.oe_b = ~port3_direction_reg[dual_timer_pkg::PIN_B];
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pins <= '0;
		end else begin
			pins <= next_pins;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_set_ch1_write;
		flop_set_ch1 && !flop_clear_ch1;
	endsequence

	sequence s_flop1_high_then_pin;
		out_flop_ch1 ##1 (pins.out_a == 1'b1);
	endsequence

	a_mode_reset_zero: assert property ($past(sys_rst) |-> counter_mode_ctrl_reg == 8'h00)
		else $error("mode control not zero after reset");
	a_out_reset_zero: assert property ($past(sys_rst) |-> output_ctrl_reg == 8'h00)
		else $error("output control not zero after reset");
	a_dir_reset_ones: assert property ($past(sys_rst) |-> port3_direction_reg == 8'hFF)
		else $error("direction register not all ones after reset");
	a_action_bits_zero: assert property (output_ctrl_reg[7:6] == 2'b00
			&& output_ctrl_reg[3:2] == 2'b00)
		else $error("set or clear bit retained");
	a_mode_bit_write: assert property (reg_req.wr && reg_req.bit_mode
			&& reg_req.addr == dual_timer_pkg::ADDR_MODE_CTRL
			|=> counter_mode_ctrl_reg[$past(reg_req.bit_sel)] == $past(reg_req.wdata[0]))
		else $error("mode bit write lost");
	a_set_drives_pin: assert property (s_set_ch1_write
			##1 output_ctrl_reg[dual_timer_pkg::OC_DRIVE_EN_CH1] && !flop_clear_ch1
			|-> s_flop1_high_then_pin)
		else $error("set did not reach pin");
	a_clear_ch2_forces: assert property (flop_clear_ch2 && !flop_set_ch2 |=> !out_flop_ch2)
		else $error("clear did not force channel 2 low");
	a_toggle_on_match: assert property (match_irq_ch1 && !flop_set_ch1 && !flop_clear_ch1
			&& output_ctrl_reg[dual_timer_pkg::OC_TOGGLE_EN_CH1]
			|=> out_flop_ch1 != $past(out_flop_ch1))
		else $error("channel 1 did not toggle on match");
	a_no_toggle_off: assert property (match_irq_ch2 && !flop_set_ch2 && !flop_clear_ch2
			&& !output_ctrl_reg[dual_timer_pkg::OC_TOGGLE_EN_CH2]
			|=> $stable(out_flop_ch2))
		else $error("channel 2 toggled while disabled");
	a_match_clears: assert property (!cascade && counter_mode_ctrl_reg[dual_timer_pkg::MODE_RUN_CH1]
			&& tick_ch1 && counter_ch1 == cmp_ch1
			|=> counter_ch1 == 8'h00 && match_irq_ch1)
		else $error("match did not clear channel 1");
	a_cascade_run: assert property (cascade
			&& !counter_mode_ctrl_reg[dual_timer_pkg::MODE_RUN_CH1]
			|=> counter_ch2 == 8'h00 && counter_ch1 == 8'h00)
		else $error("cascade ran without first run bit");
	a_pin_b_follows: assert property (output_ctrl_reg[dual_timer_pkg::OC_DRIVE_EN_CH2]
			|=> pins.out_b == $past(out_flop_ch2))
		else $error("pin b not following channel 2 flop");
	a_pin_a_port: assert property (!output_ctrl_reg[dual_timer_pkg::OC_DRIVE_EN_CH1]
			|=> pins.out_a == $past(port3_latch[dual_timer_pkg::PIN_A]))
		else $error("pin a not in port mode");
	a_pin_oe_dir: assert property (1'b1
			|=> pins.oe_a == !$past(port3_direction_reg[dual_timer_pkg::PIN_A])
			&& pins.oe_b == !$past(port3_direction_reg[dual_timer_pkg::PIN_B]))
		else $error("pin enable not following direction bit");
	a_cascade_match: assert property (cascade && tick_ch1
			&& counter_mode_ctrl_reg[dual_timer_pkg::MODE_RUN_CH1]
			&& {counter_ch2, counter_ch1} == {cmp_ch2, cmp_ch1}
			|=> match_irq_ch1 && match_irq_ch2 && counter_ch1 == 8'h00 && counter_ch2 == 8'h00)
		else $error("cascade match did not clear both halves");
	a_match_clears_ch2: assert property (!cascade && tick_ch2
			&& counter_mode_ctrl_reg[dual_timer_pkg::MODE_RUN_CH2] && counter_ch2 == cmp_ch2
			|=> counter_ch2 == 8'h00 && match_irq_ch2)
		else $error("match did not clear channel 2");
endmodule : dual_timer_output_control

// file: verif/pin_wire_model.sv
`timescale 1ns/100ps
module pin_wire_model (
	input wire dual_timer_pkg::pin_drive_t pins,
	output logic level_a,
	output logic level_b
);
	// Board pull-ups hold released pins high, so a stale drive value never reads back
	assign level_a = pins.oe_a ? pins.out_a : 1'b1;
	assign level_b = pins.oe_b ? pins.out_b : 1'b1;
endmodule : pin_wire_model

// file: verif/dual_timer_output_control_tb_top.sv
`timescale 1ns/100ps
module dual_timer_output_control_tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	dual_timer_pkg::reg_req_t reg_req = '0;
	logic tick_ch1 = 1'b0;
	logic tick_ch2 = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic match_irq_ch1;
	logic match_irq_ch2;
	logic level_a;
	logic level_b;
	dual_timer_pkg::pin_drive_t pins;
	logic [7:0] exp_q[$];
	logic [7:0] oc_seq[6] = '{8'h55, 8'h19, 8'h91, 8'hD1, 8'h5D, 8'h15};
	logic [1:0] pin_seq[6] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h2, 2'h0};
	int n_errors = 0;
	int n_checks = 0;
	int irq1 = 0;
	int irq2 = 0;
	int n1;
	logic [7:0] r;

	always #20 clk_sys = ~clk_sys;

	dual_timer_output_control dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req),
		.tick_ch1(tick_ch1), .tick_ch2(tick_ch2), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .match_irq_ch1(match_irq_ch1),
		.match_irq_ch2(match_irq_ch2), .pins(pins));
	pin_wire_model far (.pins(pins), .level_a(level_a), .level_b(level_b));

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk_cnt(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_cnt

	task automatic acc(input logic w, input logic rd, input logic b, input logic [2:0] s,
		input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_req <= '{wr: w, rd: rd, bit_mode: b, bit_sel: s, addr: a, wdata: d};
		@(negedge clk_sys);
		reg_req <= '0;
	endtask : acc

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc(1'b1, 1'b0, 1'b0, 3'h0, a, d);
	endtask : wr

	task automatic wbit(input logic [15:0] a, input logic [2:0] s, input logic v);
		acc(1'b1, 1'b0, 1'b1, s, a, {7'h00, v});
	endtask : wbit

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(1'b0, 1'b1, 1'b0, 3'h0, a, 8'h00);
	endtask : rd

	// Flop settles one edge after the write, the pin register one edge later
	task automatic pin_chk(input logic ea, input logic eb);
		repeat (2) @(negedge clk_sys);
		chk8({6'h00, level_a, level_b}, {6'h00, ea, eb});
	endtask : pin_chk

	// Channel 2 ticks whenever channel 1 does not, or always when hi2 is set
	task automatic ticks(input int cnt, input logic rnd, input logic hi2, output int n);
		logic t;
		n = 0;
		for (int i = 0; i < cnt; i++) begin
			@(negedge clk_sys);
			t = rnd ? 1'($urandom) : 1'b1;
			tick_ch1 <= t;
			tick_ch2 <= hi2 | ~t;
			n += int'(t);
		end
		@(negedge clk_sys);
		tick_ch1 <= 1'b0;
		tick_ch2 <= 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask : ticks

	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	always @(negedge clk_sys) begin
		if (match_irq_ch1 === 1'b1) irq1++;
		if (match_irq_ch2 === 1'b1) irq2++;
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) chk8(reg_rdata, 8'hXX);
			else chk8(reg_rdata, exp_q.pop_front());
		end
	end

	initial begin
		#(40 * 4000);
		n_errors++;
		summarize();
	end

	initial begin
		void'($urandom(92));
		repeat (20) @(negedge clk_sys);
		sys_rst <= 1'b0;
		rd(dual_timer_pkg::ADDR_MODE_CTRL, 8'h00);
		rd(dual_timer_pkg::ADDR_OUT_CTRL, 8'h00);
		rd(dual_timer_pkg::ADDR_PORT3_DIR, 8'hFF);
		rd(16'hFF00, 8'h00);
		pin_chk(1'b1, 1'b1);
		$display("test reset_values done");
		// Run bits kept low so the counters stay stopped
		r = 8'($urandom) & 8'hF8;
		wr(dual_timer_pkg::ADDR_MODE_CTRL, r);
		rd(dual_timer_pkg::ADDR_MODE_CTRL, r);
		wbit(dual_timer_pkg::ADDR_MODE_CTRL, 3'h7, ~r[7]);
		rd(dual_timer_pkg::ADDR_MODE_CTRL, {~r[7], r[6:0]});
		wr(dual_timer_pkg::ADDR_MODE_CTRL, 8'h00);
		r = 8'($urandom);
		// Set and clear of one channel together is prohibited, so never drive both
		r[2] = r[2] & ~r[3];
		r[6] = r[6] & ~r[7];
		wr(dual_timer_pkg::ADDR_OUT_CTRL, r);
		rd(dual_timer_pkg::ADDR_OUT_CTRL, r & 8'h33);
		wbit(dual_timer_pkg::ADDR_OUT_CTRL, 3'h5, ~r[5]);
		rd(dual_timer_pkg::ADDR_OUT_CTRL, {2'h0, ~r[5], r[4], 2'h0, r[1:0]});
		wbit(dual_timer_pkg::ADDR_PORT3_DIR, 3'h1, 1'b0);
		wbit(dual_timer_pkg::ADDR_PORT3_DIR, 3'h2, 1'b0);
		rd(dual_timer_pkg::ADDR_PORT3_DIR, 8'hF9);
		$display("test register_access done");
		wr(dual_timer_pkg::ADDR_PORT3_LATCH, 8'h02);
		wr(dual_timer_pkg::ADDR_OUT_CTRL, 8'h00);
		pin_chk(1'b1, 1'b0);
		wr(dual_timer_pkg::ADDR_PORT3_LATCH, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(dual_timer_pkg::ADDR_OUT_CTRL, oc_seq[i]);
			pin_chk(pin_seq[i][1], pin_seq[i][0]);
		end
		wbit(dual_timer_pkg::ADDR_OUT_CTRL, 3'h7, 1'b1);
		pin_chk(1'b0, 1'b1);
		rd(dual_timer_pkg::ADDR_OUT_CTRL, 8'h11);
		$display("test flop_control done");
		wr(dual_timer_pkg::ADDR_CMP_CH1, 8'h02);
		wr(dual_timer_pkg::ADDR_CMP_CH2, 8'h03);
		wr(dual_timer_pkg::ADDR_OUT_CTRL, 8'h77);
		wr(dual_timer_pkg::ADDR_MODE_CTRL, 8'h03);
		irq1 = 0;
		irq2 = 0;
		ticks(60, 1'b1, 1'b0, n1);
		chk_cnt(irq1, n1 / 3);
		chk_cnt(irq2, (60 - n1) / 4);
		pin_chk(1'((n1 / 3) % 2), 1'(((60 - n1) / 4) % 2));
		rd(dual_timer_pkg::ADDR_COUNT_CH1, 8'(n1 % 3));
		rd(dual_timer_pkg::ADDR_COUNT_CH2, 8'((60 - n1) % 4));
		wr(dual_timer_pkg::ADDR_MODE_CTRL, 8'h00);
		$display("test interval_toggle done");
		wr(dual_timer_pkg::ADDR_MODE_CTRL, 8'h04);
		wr(dual_timer_pkg::ADDR_CMP_CH1, 8'h01);
		wr(dual_timer_pkg::ADDR_CMP_CH2, 8'h01);
		wr(dual_timer_pkg::ADDR_OUT_CTRL, 8'h55);
		wr(dual_timer_pkg::ADDR_MODE_CTRL, 8'h06);
		irq1 = 0;
		irq2 = 0;
		ticks(300, 1'b0, 1'b1, n1);
		chk_cnt(irq1 + irq2, 0);
		wr(dual_timer_pkg::ADDR_MODE_CTRL, 8'h05);
		ticks(260, 1'b0, 1'b1, n1);
		chk_cnt(irq1, 1);
		chk_cnt(irq2, 1);
		rd(dual_timer_pkg::ADDR_COUNT_CH1, 8'h02);
		rd(dual_timer_pkg::ADDR_COUNT_CH2, 8'h00);
		pin_chk(1'b0, 1'b0);
		$display("test cascade done");
		repeat (4) @(negedge clk_sys);
		chk_cnt(exp_q.size(), 0);
		summarize();
	end
endmodule : dual_timer_output_control_tb_top
